/* File: rtl/deep_sleep_flags_and_doze.sv */
// Wake-source and reset-cause flags, deep-sleep entry selection and CPU doze divider
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "deep_sleep_flags_and_doze_defines.svh"

module deep_sleep_flags_and_doze
   import deep_sleep_flags_and_doze_pkg::*;
#(
   parameter int ADDR_WIDTH = 6,
   parameter int RATIO_BITS = 3
) (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Classic Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // Power-save instruction from the core
   input  wire logic                  powerSaveExec,
   input  wire logic                  powerSaveOperand,
   // Wake and reset-cause events from the power logic
   input  wire wakeEvents_type        wakeEvents,
   input  wire resetEvents_type       resetEvents,
   input  wire logic                  resetPinEnable,
   input  wire logic                  externalResetPinN,
   input  wire logic                  irqEvent,
   // Power state and CPU clock gating
   output logic                       enterSleep,
   output logic                       enterDeepSleep,
   output logic                       inDeepSleep,
   output logic                       cpuClockEnable,
   output logic                       dozeActive
);

   localparam int DIV_WIDTH   = (1 << RATIO_BITS) - 1;

   // Refuse widths that the decode and the ratio field cannot serve
   if (ADDR_WIDTH < 6 || RATIO_BITS != 3) begin : badParams
      $error("unsupported address width or ratio width");
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Byte-lane write mask for a 16-bit register
   function automatic logic [15:0] laneMask(input logic [3:0] sel);
      laneMask = {{8{sel[1]}}, {8{sel[0]}}};
   endfunction : laneMask

   // Divider terminal count for ratio code n, two to the n minus one
   function automatic logic [DIV_WIDTH-1:0] divLimit(input logic [RATIO_BITS-1:0] code);
      divLimit = DIV_WIDTH'((1 << code) - 1);
   endfunction : divLimit

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   logic                  ack_q;
   logic                  busReq;
   logic                  busWrite;
   logic [15:0]           writeMask;
   logic [15:0]           wakeRead;
   logic [15:0]           flagRead;
   logic [15:0]           controlRead;
   logic [15:0]           dividerRead;
   logic [15:0]           statusRead;
   logic [31:0]           readData_q;
   logic [31:0]           readData_d;

   assign busReq    = wb_cyc_i && wb_stb_i && !ack_q;
   assign busWrite  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // Write lands on the acked edge
   assign writeMask = laneMask(wb_sel_i);

   // One wait state: ack one edge after the request is seen
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq;
      end
   end

   // Read data captured with the ack
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readData_q <= 32'h0;
      end else if (busReq) begin
         readData_q <= readData_d;
      end
   end

   always_comb begin
      unique case (wb_adr_i)
         `OFS_DEEP_SLEEP_CONTROL: readData_d = {16'h0, controlRead};
         `OFS_WAKE_SOURCE:        readData_d = {16'h0, wakeRead};
         `OFS_RESET_POWER_FLAGS:  readData_d = {16'h0, flagRead};
         `OFS_CLOCK_DIVIDER:      readData_d = {16'h0, dividerRead};
         `OFS_POWER_STATUS:       readData_d = {16'h0, statusRead};
         default:                 readData_d = 32'h0; // Unmapped reads zero
      endcase
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = readData_q;

   // ----------------------------------------------------------------------
   // Deep-sleep control and power state
   // ----------------------------------------------------------------------
   logic           deepSleepEnable_q;
   logic           setDeepSleepEnable;
   logic           anyWake;
   powerState_type state_q;

   assign setDeepSleepEnable = busWrite && (wb_adr_i == `OFS_DEEP_SLEEP_CONTROL)
                               && writeMask[`BIT_DEEP_SLEEP_ENABLE]
                               && wb_dat_i[`BIT_DEEP_SLEEP_ENABLE];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         deepSleepEnable_q <= `RST_DEEP_SLEEP_ENABLE;
      end else if (busWrite && (wb_adr_i == `OFS_DEEP_SLEEP_CONTROL)
                   && writeMask[`BIT_DEEP_SLEEP_ENABLE]) begin
         deepSleepEnable_q <= wb_dat_i[`BIT_DEEP_SLEEP_ENABLE];
      end
   end

   assign controlRead = 16'(deepSleepEnable_q) << `BIT_DEEP_SLEEP_ENABLE;

   // Power-save choice of sleep depth
   assign enterDeepSleep = powerSaveExec && !powerSaveOperand && deepSleepEnable_q;
   assign enterSleep     = powerSaveExec && !(!powerSaveOperand && deepSleepEnable_q);

   // Run, sleep and deep-sleep tracking; an interrupt returns sleep to run, any wake source returns deep sleep to run
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= RUN_STATE;
      end else begin
         unique case (state_q)
            RUN_STATE: begin
               if (enterDeepSleep) begin
                  state_q <= DEEP_SLEEP_STATE;
               end else if (enterSleep) begin
                  state_q <= SLEEP_STATE;
               end
            end
            SLEEP_STATE: begin
               if (irqEvent) begin
                  state_q <= RUN_STATE;
               end
            end
            DEEP_SLEEP_STATE: begin
               if (anyWake) begin
                  state_q <= RUN_STATE;
               end
            end
            default: state_q <= RUN_STATE;
         endcase
      end
   end

   assign inDeepSleep = (state_q == DEEP_SLEEP_STATE);

   // ----------------------------------------------------------------------
   // External reset pin synchroniser
   // ----------------------------------------------------------------------
   logic [2:0] pinSync_q;
   logic       pinLevel_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinSync_q <= 3'h7;
      end else begin
         pinSync_q <= {pinSync_q[1:0], externalResetPinN};
      end
   end

   // Level taken once stages two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinLevel_q <= 1'b1;
      end else if (pinSync_q[1] == pinSync_q[2]) begin
         pinLevel_q <= pinSync_q[2];
      end
   end

   // ----------------------------------------------------------------------
   // Wake-source register
   // ----------------------------------------------------------------------
   logic [15:0] wakeImpl;
   logic [15:0] wakeSet;
   logic [15:0] wake_q;
   logic        wakeWrite;

   assign wakeImpl = (16'h1 << `BIT_WAKE_PIN_CHANGE) | (16'h1 << `BIT_WAKE_FAULT)
                   | (16'h1 << `BIT_WAKE_WATCHDOG) | (16'h1 << `BIT_WAKE_CALENDAR)
                   | (16'h1 << `BIT_WAKE_RESET_PIN);

   // Hardware set terms, only while in deep sleep
   always_comb begin
      wakeSet = 16'h0;
      wakeSet[`BIT_WAKE_PIN_CHANGE] = inDeepSleep && wakeEvents.pinChange;
      wakeSet[`BIT_WAKE_FAULT]      = inDeepSleep && wakeEvents.fault;
      wakeSet[`BIT_WAKE_WATCHDOG]   = inDeepSleep && wakeEvents.watchdog;
      wakeSet[`BIT_WAKE_CALENDAR]   = inDeepSleep && wakeEvents.calendar;
      wakeSet[`BIT_WAKE_RESET_PIN]  = inDeepSleep && resetPinEnable && !pinLevel_q;
   end

   assign anyWake   = |wakeSet;
   assign wakeWrite = busWrite && (wb_adr_i == `OFS_WAKE_SOURCE);

   // Set wins over both the bulk clear and a software write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_q <= 16'h0;
      end else if (setDeepSleepEnable) begin
         wake_q <= wakeSet;
      end else if (wakeWrite) begin
         wake_q <= (((wake_q & ~writeMask) | (wb_dat_i[15:0] & writeMask)) | wakeSet) & wakeImpl;
      end else begin
         wake_q <= (wake_q | wakeSet) & wakeImpl;
      end
   end

   assign wakeRead = wake_q & wakeImpl;

   // ----------------------------------------------------------------------
   // Reset-cause flags
   // ----------------------------------------------------------------------
   logic [3:0]  flags_q;
   logic [3:0]  flagSet;
   logic [3:0]  flagClear;

   assign flagSet = {resetEvents.brownout, resetEvents.powerOn,
                     resetEvents.backupLoss, resetEvents.backupWake};
   // Writing zero clears, writing one leaves the flag
   assign flagClear = (busWrite && (wb_adr_i == `OFS_RESET_POWER_FLAGS) && wb_sel_i[0])
                      ? ~wb_dat_i[3:0] : 4'h0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= {`RST_SUPPLY_BROWNOUT, `RST_SUPPLY_POWER_ON,
                     `RST_BACKUP_POWER_LOSS, `RST_BACKUP_WAKE};
      end else begin
         flags_q <= (flags_q & ~flagClear) | flagSet;
      end
   end

   assign flagRead = {12'h0, flags_q};

   // ----------------------------------------------------------------------
   // Clock divider control and doze
   // ----------------------------------------------------------------------
   logic                  recoverOnIrq_q;
   logic [RATIO_BITS-1:0] ratio_q;
   logic                  slowCpuEnable_q;
   logic                  dividerWrite;
   logic [DIV_WIDTH-1:0]  dozeCount_q;

   assign dividerWrite = busWrite && (wb_adr_i == `OFS_CLOCK_DIVIDER) && wb_sel_i[1];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         recoverOnIrq_q <= `RST_RECOVER_ON_IRQ;
         ratio_q        <= `RST_RATIO;
      end else if (dividerWrite) begin
         recoverOnIrq_q <= wb_dat_i[`BIT_RECOVER_ON_IRQ];
         ratio_q        <= wb_dat_i[`BIT_RATIO_HI:`BIT_RATIO_LO];
      end
   end

   // Interrupt drop out of doze wins over a software write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slowCpuEnable_q <= `RST_SLOW_CPU_ENABLE;
      end else if (irqEvent && recoverOnIrq_q) begin
         slowCpuEnable_q <= 1'b0;
      end else if (dividerWrite) begin
         slowCpuEnable_q <= wb_dat_i[`BIT_SLOW_CPU_ENABLE];
      end
   end

   assign dozeActive = slowCpuEnable_q;

   // Divider on the peripheral clock; CPU edges are a subset of peripheral edges
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dozeCount_q <= '0;
      end else if (!slowCpuEnable_q || dozeCount_q >= divLimit(ratio_q)) begin
         dozeCount_q <= '0;
      end else begin
         dozeCount_q <= dozeCount_q + 1'b1;
      end
   end

   assign cpuClockEnable = !slowCpuEnable_q || (dozeCount_q == '0);

   assign dividerRead = (16'(recoverOnIrq_q) << `BIT_RECOVER_ON_IRQ)
                      | (16'(ratio_q) << `BIT_RATIO_LO)
                      | (16'(slowCpuEnable_q) << `BIT_SLOW_CPU_ENABLE);
   assign statusRead  = {13'h0, state_q};

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking defClk @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence deepSleepPinChange;
      inDeepSleep && wakeEvents.pinChange && !setDeepSleepEnable;
   endsequence

   pin_change_flag_a: assert property (deepSleepPinChange |=> wake_q[`BIT_WAKE_PIN_CHANGE])
      else $error("pin-change wake flag not set");
   fault_flag_a: assert property (inDeepSleep && wakeEvents.fault |=> wake_q[`BIT_WAKE_FAULT])
      else $error("fault wake flag not set");
   watchdog_flag_a: assert property (inDeepSleep && wakeEvents.watchdog |=> wake_q[`BIT_WAKE_WATCHDOG])
      else $error("watchdog wake flag not set");
   calendar_flag_a: assert property (inDeepSleep && wakeEvents.calendar |=> wake_q[`BIT_WAKE_CALENDAR])
      else $error("calendar wake flag not set");
   reset_pin_flag_a: assert property ($rose(wake_q[`BIT_WAKE_RESET_PIN]) && !$past(wakeWrite)
                                      |-> $past(resetPinEnable && inDeepSleep && !pinLevel_q))
      else $error("reset-pin wake flag set without cause");
   wake_bulk_clear_a: assert property (setDeepSleepEnable && !anyWake |=> wake_q == 16'h0)
      else $error("wake sources not cleared by deep-sleep enable");
   unimpl_zero_a: assert property ((wakeRead & 16'hfe63) == 16'h0 && flagRead[15:4] == 12'h0)
      else $error("unimplemented bit reads one");
   flag_hw_set_a: assert property (|flagSet |=> (flags_q & $past(flagSet)) == $past(flagSet))
      else $error("reset flag lost its hardware set");
   flag_no_sw_set_a: assert property ((flags_q & ~$past(flags_q)) == (flags_q & ~$past(flags_q) & $past(flagSet)))
      else $error("reset flag set without hardware event");
   recover_irq_a: assert property (irqEvent && recoverOnIrq_q && slowCpuEnable_q |=> !slowCpuEnable_q
                                   ##0 cpuClockEnable)
      else $error("interrupt did not restore full speed");
   keep_doze_a: assert property (irqEvent && !recoverOnIrq_q && !dividerWrite && slowCpuEnable_q
                                 |=> slowCpuEnable_q && $stable(ratio_q))
      else $error("interrupt disturbed doze");
   full_rate_a: assert property (!slowCpuEnable_q |-> cpuClockEnable)
      else $error("CPU slowed with doze off");
   doze_start_a: assert property ($rose(slowCpuEnable_q) |-> cpuClockEnable)
      else $error("CPU enable not aligned at doze start");
   sequence dozeTwoRatio;
      slowCpuEnable_q && ratio_q == 3'h1 && cpuClockEnable && !dividerWrite && !irqEvent;
   endsequence
   half_rate_a: assert property (dozeTwoRatio |=> !cpuClockEnable)
      else $error("ratio two did not halve CPU rate");
   deep_entry_a: assert property (powerSaveExec && !powerSaveOperand && deepSleepEnable_q
                                  && state_q == RUN_STATE |=> inDeepSleep)
      else $error("deep sleep not entered");

endmodule : deep_sleep_flags_and_doze

/* File: rtl/deep_sleep_flags_and_doze_defines.svh */
// Register offsets, field positions and reset values of the deep-sleep flags and doze block
`ifndef DEEP_SLEEP_FLAGS_AND_DOZE_DEFINES_SVH
`define DEEP_SLEEP_FLAGS_AND_DOZE_DEFINES_SVH

// ----------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------
`define OFS_DEEP_SLEEP_CONTROL   6'h00
`define OFS_WAKE_SOURCE          6'h04
`define OFS_RESET_POWER_FLAGS    6'h08
`define OFS_CLOCK_DIVIDER        6'h0c
`define OFS_POWER_STATUS         6'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_DEEP_SLEEP_ENABLE    15
`define BIT_WAKE_PIN_CHANGE      8
`define BIT_WAKE_FAULT           7
`define BIT_WAKE_WATCHDOG        4
`define BIT_WAKE_CALENDAR        3
`define BIT_WAKE_RESET_PIN       2
`define BIT_SUPPLY_BROWNOUT      3
`define BIT_SUPPLY_POWER_ON      2
`define BIT_BACKUP_POWER_LOSS    1
`define BIT_BACKUP_WAKE          0
`define BIT_RECOVER_ON_IRQ       15
`define BIT_RATIO_HI             14
`define BIT_RATIO_LO             12
`define BIT_SLOW_CPU_ENABLE      11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_DEEP_SLEEP_ENABLE    1'b0
`define RST_SUPPLY_BROWNOUT      1'b1
`define RST_SUPPLY_POWER_ON      1'b1
`define RST_BACKUP_POWER_LOSS    1'b1
`define RST_BACKUP_WAKE          1'b0
`define RST_RECOVER_ON_IRQ       1'b0
`define RST_RATIO                3'h0
`define RST_SLOW_CPU_ENABLE      1'b0

`endif

/* File: rtl/deep_sleep_flags_and_doze_pkg.sv */
// Types shared by the deep-sleep flags and doze block
package deep_sleep_flags_and_doze_pkg;

   // Power state, one-hot
   typedef enum logic [2:0] {
      RUN_STATE        = 3'b001,
      SLEEP_STATE      = 3'b010,
      DEEP_SLEEP_STATE = 3'b100
   } powerState_type;

   // Events that may wake the device from deep sleep
   typedef struct packed {
      logic pinChange;
      logic fault;
      logic watchdog;
      logic calendar;
   } wakeEvents_type;

   // Events that raise the reset-cause flags
   typedef struct packed {
      logic brownout;
      logic powerOn;
      logic backupLoss;
      logic backupWake;
   } resetEvents_type;

endpackage : deep_sleep_flags_and_doze_pkg

/* File: testbench/tb_deep_sleep_flags_and_doze.sv */
// Self-checking bench for the deep-sleep flags and doze block
`timescale 1ns/10ps
module tb_deep_sleep_flags_and_doze
   import deep_sleep_flags_and_doze_pkg::*;
;
   localparam logic [5:0] CTL_A = 6'h00;
   localparam logic [5:0] WAKE_A = 6'h04;
   localparam logic [5:0] RST_A = 6'h08;
   localparam logic [5:0] DIV_A = 6'h0c;
   localparam logic [5:0] STA_A = 6'h10;

   logic            clk, resetn, cyc, stb, we, pse, pso, rpe, pinN, irq;
   logic            ack, eSl, eDs, inDs, cpuEn, doze;
   logic [5:0]      adr;
   logic [3:0]      sel;
   logic [31:0]     wdat, rdat;
   wakeEvents_type  wk;
   resetEvents_type rs;
   int              errTotal = 0;
   int              comparisons = 0;
   int              cnt;
   int              pos [4] = '{8, 7, 4, 3};

   deep_sleep_flags_and_doze dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .powerSaveExec(pse),
      .powerSaveOperand(pso), .wakeEvents(wk), .resetEvents(rs), .resetPinEnable(rpe), .externalResetPinN(pinN),
      .irqEvent(irq), .enterSleep(eSl), .enterDeepSleep(eDs), .inDeepSleep(inDs), .cpuClockEnable(cpuEn),
      .dozeActive(doze));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Classic single Wishbone cycle, held until ack is seen
   task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, 16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      chk("ack", 32'h1, {31'h0, ack});
      {cyc, stb, we} <= 3'b000;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, exp, q);
   endtask : rd

   // Power-save with operand zero; exp is {deep, normal}
   task automatic nap(input logic [31:0] exp);
      @(posedge clk);
      {pse, pso} <= 2'b10;
      @(negedge clk);
      chk("enter", exp, {30'h0, eDs, eSl});
      @(posedge clk);
      pse <= 1'b0;
   endtask : nap

   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrapUp

   // Clock of 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard
   initial begin
      repeat (30000) @(posedge clk);
      errTotal++;
      wrapUp();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {resetn, cyc, stb, we, pse, pso, rpe, irq, adr, sel, wdat} = '0;
      {wk, rs, pinN} = 9'h001;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(RST_A, 32'h0000000e, "flags");
      rd(DIV_A, 32'h0, "divider");
      rd(6'h3c, 32'h0, "unmapped");
      wr(RST_A, 16'hffff);
      rd(RST_A, 32'h0000000e, "flags");
      wr(RST_A, 16'h0000);
      rd(RST_A, 32'h0, "flags");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rs <= resetEvents_type'(4'h8 >> i);
         @(posedge clk);
         rs <= '0;
         rd(RST_A, 32'h8 >> i, "flags");
         wr(RST_A, 16'h0000);
      end
      $display("reset flags test done");
      for (int i = 0; i < 4; i++) begin
         wr(CTL_A, 16'h8000);
         rd(WAKE_A, 32'h0, "wake");
         nap(32'h2);
         @(negedge clk);
         chk("inDeepSleep", 32'h1, {31'h0, inDs});
         @(posedge clk);
         wk <= wakeEvents_type'(4'h8 >> i);
         @(posedge clk);
         wk <= '0;
         rd(WAKE_A, 32'h1 << pos[i], "wake");
      end
      wr(WAKE_A, 16'hffff);
      rd(WAKE_A, 32'h0000019c, "wake");
      wr(CTL_A, 16'h8000);
      nap(32'h2);
      @(posedge clk);
      pinN <= 1'b0;
      repeat (8) @(posedge clk);
      rd(WAKE_A, 32'h0, "wake");
      rpe <= 1'b1;
      repeat (8) @(posedge clk);
      pinN <= 1'b1;
      rd(WAKE_A, 32'h4, "wake");
      $display("wake source test done");
      wr(CTL_A, 16'h0000);
      nap(32'h1);
      rd(STA_A, 32'h2, "state");
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rd(STA_A, 32'h1, "state");
      $display("sleep test done");
      for (int n = 0; n < 8; n++) begin
         wr(DIV_A, 16'h0000);
         wr(DIV_A, 16'(n << 12) | 16'h0800);
         cnt = 0;
         repeat (4 << n) begin
            @(negedge clk);
            if (cpuEn === 1'b1) cnt++;
         end
         chk("cpu enables", 32'd4, cnt);
         chk("dozeActive", 32'h1, {31'h0, doze});
      end
      wr(DIV_A, 16'h7000);
      cnt = 0;
      repeat (8) begin
         @(negedge clk);
         if (cpuEn === 1'b1) cnt++;
      end
      chk("cpu enables", 32'd8, cnt);
      chk("dozeActive", 32'h0, {31'h0, doze});
      wr(DIV_A, 16'hb800);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      @(negedge clk);
      chk("dozeActive", 32'h0, {31'h0, doze});
      chk("cpuClockEnable", 32'h1, {31'h0, cpuEn});
      rd(DIV_A, 32'h0000b000, "divider");
      wr(DIV_A, 16'h3800);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rd(DIV_A, 32'h00003800, "divider");
      chk("dozeActive", 32'h1, {31'h0, doze});
      $display("doze test done");
      wrapUp();
   end
endmodule : tb_deep_sleep_flags_and_doze
